//--- logic/dpr_core.sv
// DDR2 device command block: auto-precharge, refresh and power-down states
`timescale 1ns/100ps
module dpr_core (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire dpr_pkg::dpr_pins_type pins,
  input wire dpr_pkg::dpr_mode_type mode,
  output dpr_pkg::dpr_cmd_type cmd,
  output dpr_pkg::dpr_pwr_type pwr_state,
  output dpr_pkg::dpr_bank_type bank_status,
  output dpr_pkg::dpr_power_type power,
  output logic [dpr_pkg::ROW_W-1:0] refresh_row,
  output logic refresh_strobe,
  output logic protocol_error
);
  import dpr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  dpr_pins_type pins_s1_reg, pins_s2_reg;
  logic cke_prev_reg;

  // Two flops before any logic reads the pins
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pins_s1_reg <= '0;
      pins_s2_reg <= '0;
      cke_prev_reg <= 1'b0;
    end else begin
      pins_s1_reg <= pins;
      pins_s2_reg <= pins_s1_reg;
      cke_prev_reg <= pins_s2_reg.cke;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode
  dpr_cmd_type cmd_dec;
  logic nop_like;

  assign nop_like = pins_s2_reg.cs_n ||
                    (pins_s2_reg.ras_n && pins_s2_reg.cas_n && pins_s2_reg.we_n);

  // Decode on previous and current CKE with the command pins
  always_comb begin
    cmd_dec = CMD_NOP;
    if (!cke_prev_reg) begin
      if (pins_s2_reg.cke && nop_like) begin
        cmd_dec = CMD_EXIT;
      end else begin
        cmd_dec = CMD_NOP;
      end
    end else if (!pins_s2_reg.cke) begin
      if (nop_like) begin
        cmd_dec = CMD_PDE;
      end else if (!pins_s2_reg.ras_n && !pins_s2_reg.cas_n && pins_s2_reg.we_n) begin
        cmd_dec = CMD_SELF;
      end else begin
        cmd_dec = CMD_ILLEGAL;
      end
    end else if (pins_s2_reg.cs_n) begin
      cmd_dec = CMD_DESEL;
    end else begin
      case ({pins_s2_reg.ras_n, pins_s2_reg.cas_n, pins_s2_reg.we_n})
        3'h0: cmd_dec = CMD_MRS;
        3'h1: cmd_dec = CMD_REF;
        3'h2: cmd_dec = CMD_PRE;
        3'h3: cmd_dec = CMD_ACT;
        3'h4: cmd_dec = CMD_WR;
        3'h5: cmd_dec = CMD_RD;
        default: cmd_dec = CMD_NOP;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power state machine
  dpr_pwr_type pwr_reg, pwr_next;
  logic [CNT_W-1:0] rfc_reg, rfc_next;
  logic err_reg, err_next;
  logic any_open;
  logic live;

  // Bank and refresh commands only act while awake
  assign live = (pwr_reg == PS_ACTIVE);

  // Next power state, refresh busy time and error flag
  always_comb begin
    pwr_next = pwr_reg;
    rfc_next = (rfc_reg != CNT_RESET) ? rfc_reg - 8'h01 : rfc_reg;
    err_next = err_reg;
    case (pwr_reg)
      PS_ACTIVE: begin
        if (cmd_dec == CMD_PDE) begin
          // Mode chosen by open banks and the A12 mode bit
          if (!any_open) begin
            pwr_next = PS_PRE_PD;
          end else if (mode.pd_slow) begin
            pwr_next = PS_ACT_PD_SLOW;
          end else begin
            pwr_next = PS_ACT_PD_FAST;
          end
        end else if (cmd_dec == CMD_SELF) begin
          pwr_next = PS_SELF;
        end else if (cmd_dec == CMD_REF) begin
          rfc_next = TRFC_CYC;
        end
        if (cmd_dec == CMD_ILLEGAL) begin
          err_next = 1'b1;
        end
        // Refresh with an open bank breaks the controller's side
        if (cmd_dec == CMD_REF && any_open) begin
          err_next = 1'b1;
        end
        if (cmd_dec == CMD_WR && (mode.wr < WR_MIN || mode.wr > WR_MAX)) begin
          err_next = 1'b1;
        end
      end
      PS_PRE_PD, PS_ACT_PD_FAST, PS_ACT_PD_SLOW: begin
        if (cmd_dec == CMD_EXIT) begin
          pwr_next = PS_ACTIVE;
        end
      end
      PS_SELF: begin
        // Exit needs CKE high with NOP or deselect on the command pins
        if (cmd_dec == CMD_EXIT) begin
          pwr_next = PS_ACTIVE;
        end
      end
      default: pwr_next = PS_ACTIVE;
    endcase
  end

  // Power state registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pwr_reg <= PS_ACTIVE;
      rfc_reg <= CNT_RESET;
      err_reg <= 1'b0;
    end else begin
      pwr_reg <= pwr_next;
      rfc_reg <= rfc_next;
      err_reg <= err_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Banks
  logic [NUM_BANKS-1:0] open_vec, prech_vec;
  logic [CNT_W-1:0] wr_ap_delay;

  // Burst end plus write recovery, counted from the write command
  assign wr_ap_delay = CNT_W'({4'h0, mode.wl} + {4'h0, mode.bl_half} + {5'h00, mode.wr});

  // One timer per bank; other banks keep taking commands
  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    logic hit;
    assign hit = live && (pins_s2_reg.bank == BANK_W'(b));
    dpr_bank_timer u_bank (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .act(hit && cmd_dec == CMD_ACT),
      .pre(live && cmd_dec == CMD_PRE && (hit || pins_s2_reg.a10)),
      .wr_ap(hit && cmd_dec == CMD_WR && pins_s2_reg.a10),
      .wr_ap_delay(wr_ap_delay),
      .open_now(open_vec[b]),
      .precharging(prech_vec[b])
    );
  end

  assign any_open = |open_vec;

  ////////////////////////////////////////////////////////////////////////////
  // Refresh row counter
  dpr_refresh_counter u_refresh (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .auto_ref(live && cmd_dec == CMD_REF),
    .self_mode(pwr_reg == PS_SELF),
    .ref_row(refresh_row),
    .row_strobe(refresh_strobe)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  dpr_power_type power_next, power_reg;
  dpr_cmd_type cmd_reg;

  // Buffer and DLL enables by power state
  always_comb begin
    power_next.in_buf_en = (pwr_next == PS_ACTIVE);
    power_next.out_buf_en = (pwr_next == PS_ACTIVE);
    power_next.dll_en = (pwr_next == PS_ACTIVE) || (pwr_next == PS_ACT_PD_FAST);
    power_next.refresh_busy = (rfc_next != CNT_RESET) || (pwr_next == PS_SELF);
  end

  // Output registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      power_reg <= '0;
      cmd_reg <= CMD_NOP;
    end else begin
      power_reg <= power_next;
      cmd_reg <= cmd_dec;
    end
  end

  assign power = power_reg;
  assign cmd = cmd_reg;
  assign pwr_state = pwr_reg;
  assign bank_status.open = open_vec;
  assign bank_status.precharging = prech_vec;
  assign protocol_error = err_reg;
endmodule : dpr_core

//--- logic/dpr_pkg.sv
// Package for the DDR2 precharge, refresh and power-down command block
package dpr_pkg;
  // Bank count and widths
  localparam int NUM_BANKS = 4;
  localparam int BANK_W = 2;
  localparam int ROW_W = 13;
  localparam int CNT_W = 8;
  // Row count that the refresh counter walks through
  localparam logic [ROW_W-1:0] ROW_LAST = 13'h1fff;
  localparam logic [ROW_W-1:0] ROW_RESET = 13'h0000;
  // Clock period in ps and analog timings in ps
  localparam int CLK_PS = 4000;
  localparam int TRAS_PS = 45000;
  localparam int TRP_PS = 15000;
  localparam int TRFC_PS = 105000;
  // Self-refresh internal timer: 7.8 us in ns
  localparam int TREFI_NS = 7800;
  // Derived cycle counts; least times round up, never below one cycle
  localparam logic [CNT_W-1:0] TRAS_CYC = CNT_W'((TRAS_PS + CLK_PS - 1) / CLK_PS);
  localparam logic [CNT_W-1:0] TRP_CYC = CNT_W'((TRP_PS + CLK_PS - 1) / CLK_PS);
  localparam logic [CNT_W-1:0] TRFC_CYC = CNT_W'((TRFC_PS + CLK_PS - 1) / CLK_PS);
  localparam int TREFI_CYC = (TREFI_NS * 1000) / CLK_PS;
  // Mode register field limits for write recovery
  localparam logic [2:0] WR_MIN = 3'h2;
  localparam logic [2:0] WR_MAX = 3'h6;
  // Reset values
  localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;
  localparam logic [BANK_W-1:0] BANK_RESET = 2'h0;

  // Decoded command
  typedef enum logic [3:0] {
    CMD_NOP, CMD_DESEL, CMD_MRS, CMD_REF, CMD_SELF, CMD_PRE, CMD_ACT,
    CMD_WR, CMD_RD, CMD_PDE, CMD_EXIT, CMD_ILLEGAL
  } dpr_cmd_type;

  // Power state of the device
  typedef enum logic [2:0] {
    PS_ACTIVE, PS_PRE_PD, PS_ACT_PD_FAST, PS_ACT_PD_SLOW, PS_SELF
  } dpr_pwr_type;

  // Command pins as sampled
  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [BANK_W-1:0] bank;
    logic a10;
  } dpr_pins_type;

  // Mode register fields the block uses
  typedef struct packed {
    logic [2:0] wr;
    logic [3:0] wl;
    logic [3:0] bl_half;
    logic pd_slow;
  } dpr_mode_type;

  // Per-bank status
  typedef struct packed {
    logic [NUM_BANKS-1:0] open;
    logic [NUM_BANKS-1:0] precharging;
  } dpr_bank_type;

  // Buffer and DLL enables
  typedef struct packed {
    logic in_buf_en;
    logic out_buf_en;
    logic dll_en;
    logic refresh_busy;
  } dpr_power_type;
endpackage : dpr_pkg

//--- logic/dpr_bank_timer.sv
// One bank: open state, tRAS hold-off for auto-precharge only, and write auto-precharge countdown
`timescale 1ns/100ps
module dpr_bank_timer (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic act,
  input wire logic pre,
  input wire logic wr_ap,
  input wire logic [dpr_pkg::CNT_W-1:0] wr_ap_delay,
  output logic open_now,
  output logic precharging
);
  import dpr_pkg::*;

  logic open_reg, open_next;
  logic ap_pend_reg, ap_pend_next;
  logic [CNT_W-1:0] ras_reg, ras_next;
  logic [CNT_W-1:0] ap_reg, ap_next;
  logic [CNT_W-1:0] rp_reg, rp_next;

  // Next state of the bank
  always_comb begin
    open_next = open_reg;
    ap_pend_next = ap_pend_reg;
    ras_next = (ras_reg != CNT_RESET) ? ras_reg - 8'h01 : ras_reg;
    ap_next = (ap_reg != CNT_RESET) ? ap_reg - 8'h01 : ap_reg;
    rp_next = (rp_reg != CNT_RESET) ? rp_reg - 8'h01 : rp_reg;
    if (act) begin
      open_next = 1'b1;
      ras_next = TRAS_CYC;
    end
    if (wr_ap) begin
      ap_pend_next = 1'b1;
      ap_next = wr_ap_delay;
    end
    // Precharge after burst plus WR, held off until tRAS is met
    if (ap_pend_reg && ap_reg == CNT_RESET && ras_reg == CNT_RESET) begin
      ap_pend_next = 1'b0;
      open_next = 1'b0;
      rp_next = TRP_CYC;
    end
    if (pre && open_reg) begin
      open_next = 1'b0;
      rp_next = TRP_CYC;
    end
  end

  // Bank registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      open_reg <= 1'b0;
      ap_pend_reg <= 1'b0;
      ras_reg <= CNT_RESET;
      ap_reg <= CNT_RESET;
      rp_reg <= CNT_RESET;
    end else begin
      open_reg <= open_next;
      ap_pend_reg <= ap_pend_next;
      ras_reg <= ras_next;
      ap_reg <= ap_next;
      rp_reg <= rp_next;
    end
  end

  assign open_now = open_reg;
  assign precharging = (rp_reg != CNT_RESET);
endmodule : dpr_bank_timer

//--- logic/dpr_refresh_counter.sv
// Internal refresh row counter and self-refresh interval timer
`timescale 1ns/100ps
module dpr_refresh_counter (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic auto_ref,
  input wire logic self_mode,
  output logic [dpr_pkg::ROW_W-1:0] ref_row,
  output logic row_strobe
);
  import dpr_pkg::*;

  localparam int TW = $clog2(TREFI_CYC + 1);
  localparam logic [TW-1:0] TIMER_LAST = TW'(TREFI_CYC - 1);

  logic [ROW_W-1:0] row_reg, row_next;
  logic [TW-1:0] tmr_reg, tmr_next;
  logic strobe_reg, strobe_next;
  logic tick;

  // Self-refresh tick from the built-in timer
  assign tick = self_mode && (tmr_reg == TIMER_LAST);

  // Row advance on auto-refresh or timer tick
  always_comb begin
    tmr_next = self_mode ? ((tick) ? '0 : tmr_reg + 1'b1) : '0;
    row_next = row_reg;
    strobe_next = auto_ref | tick;
    if (auto_ref | tick) begin
      row_next = (row_reg == ROW_LAST) ? ROW_RESET : row_reg + 13'h0001;
    end
  end

  // Counter registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      row_reg <= ROW_RESET;
      tmr_reg <= '0;
      strobe_reg <= 1'b0;
    end else begin
      row_reg <= row_next;
      tmr_reg <= tmr_next;
      strobe_reg <= strobe_next;
    end
  end

  assign ref_row = row_reg;
  assign row_strobe = strobe_reg;
endmodule : dpr_refresh_counter

//--- testbench/dpr_ctrl_model.sv
// Memory controller model driving the command pins of the block
`timescale 1ns/100ps
module dpr_ctrl_model (
  input wire logic core_clk,
  output dpr_pkg::dpr_pins_type pins
);
  import dpr_pkg::*;
  // Caller keeps refresh spacing, termination, DLL and entry delays
  // Idle deselect with clock enable high
  initial pins = 8'hf8;
  // One command, then NOPs for the spacing the caller asks
  task automatic issue(input logic cke, input logic [3:0] c, input logic [1:0] b,
    input logic a, input int gap);
    @(posedge core_clk);
    pins <= {cke, c, b, a};
    repeat (gap) begin
      @(posedge core_clk);
      pins <= {cke, 4'h7, ~b, ~a}; // Address no longer held
    end
  endtask : issue
endmodule : dpr_ctrl_model

//--- testbench/dpr_core_monitor.sv
// Assertion checker for the DDR2 command block ports
`timescale 1ns/100ps
module dpr_core_monitor (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire dpr_pkg::dpr_pins_type pins,
  input wire dpr_pkg::dpr_mode_type mode,
  input wire dpr_pkg::dpr_cmd_type cmd,
  input wire dpr_pkg::dpr_pwr_type pwr_state,
  input wire dpr_pkg::dpr_bank_type bank_status,
  input wire dpr_pkg::dpr_power_type power,
  input wire logic [dpr_pkg::ROW_W-1:0] refresh_row,
  input wire logic refresh_strobe
);
  import dpr_pkg::*;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  // Command classes on the pins and the expected power-down kind
  wire is_ref = !pins.cs_n && !pins.ras_n && !pins.cas_n && pins.we_n;
  wire is_nop = pins.cs_n || (pins.ras_n && pins.cas_n && pins.we_n);
  dpr_pwr_type pd_exp;
  assign pd_exp = (bank_status.open == 4'h0) ? PS_PRE_PD :
    (mode.pd_slow ? PS_ACT_PD_SLOW : PS_ACT_PD_FAST);
  ////////////////////////////////////////////////////////////
  a_ref_decode: assert property (pins.cke && $past(pins.cke) && is_ref &&
    pwr_state == PS_ACTIVE |-> ##3 cmd == CMD_REF) else $error("refresh not decoded");
  a_ref_busy_len: assert property ($rose(power.refresh_busy) && pwr_state == PS_ACTIVE
    |-> ##26 power.refresh_busy ##1 !power.refresh_busy) else $error("refresh length");
  a_ref_leaves_idle: assert property ($fell(power.refresh_busy) |->
    bank_status.open == 4'h0) else $error("bank open after refresh");
  a_self_entry: assert property (!pins.cke && $past(pins.cke) && is_ref &&
    pwr_state == PS_ACTIVE |-> ##3 pwr_state == PS_SELF) else $error("no self refresh");
  a_self_hold: assert property (pwr_state == PS_SELF && !pins.cke &&
    !$past(pins.cke) && !$past(pins.cke, 2) |=> pwr_state == PS_SELF) else $error("left self");
  a_pd_entry: assert property (!pins.cke && $past(pins.cke) && is_nop &&
    pwr_state == PS_ACTIVE |-> ##3 pwr_state == pd_exp) else $error("wrong power-down");
  a_pd_buffers: assert property ($stable(pwr_state) && pwr_state inside {PS_PRE_PD,
    PS_ACT_PD_FAST, PS_ACT_PD_SLOW} |-> !power.in_buf_en && !power.out_buf_en &&
    power.dll_en == (pwr_state == PS_ACT_PD_FAST)) else $error("buffers in power-down");
  a_pd_exit: assert property (pins.cke && !$past(pins.cke) && is_nop &&
    pwr_state != PS_ACTIVE |-> ##3 pwr_state == PS_ACTIVE) else $error("no exit");
  a_pre_length: assert property ($rose(bank_status.precharging[1]) |->
    bank_status.precharging[1] [*4] ##1 !bank_status.precharging[1]) else $error("tRP");
  a_strobe_row_step: assert property (refresh_strobe |->
    refresh_row != $past(refresh_row)) else $error("refresh row did not advance");
endmodule : dpr_core_monitor

bind dpr_core dpr_core_monitor u_dpr_core_monitor (
  .core_clk(core_clk), .arst_n(arst_n), .pins(pins), .mode(mode), .cmd(cmd),
  .pwr_state(pwr_state), .bank_status(bank_status), .power(power),
  .refresh_row(refresh_row), .refresh_strobe(refresh_strobe)
);

//--- testbench/test_ddr2_precharge_refresh_powerdown.sv
// Self-checking testbench for the DDR2 command block
`timescale 1ns/100ps
module test_ddr2_precharge_refresh_powerdown;
  import dpr_pkg::*;
  localparam logic [3:0] C_NOP = 4'h7;
  localparam logic [3:0] C_ACT = 4'h3;
  localparam logic [3:0] C_WR = 4'h4;
  localparam logic [3:0] C_REF = 4'h1;
  localparam logic [3:0] C_PRE = 4'h2;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  dpr_mode_type mode = {3'h3, 4'h3, 4'h2, 1'b0};
  dpr_pins_type pins;
  dpr_cmd_type cmd;
  dpr_pwr_type pwr_state;
  dpr_bank_type bank_status;
  dpr_power_type power;
  logic [ROW_W-1:0] refresh_row;
  logic protocol_error;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;
  dpr_pwr_type pd_tab [3] = '{PS_PRE_PD, PS_ACT_PD_FAST, PS_ACT_PD_SLOW};

  dpr_ctrl_model u_dpr_ctrl_model (.core_clk(core_clk), .pins(pins));
  dpr_core u_dpr_core (
    .core_clk(core_clk), .arst_n(arst_n), .pins(pins), .mode(mode), .cmd(cmd),
    .pwr_state(pwr_state), .bank_status(bank_status), .power(power),
    .refresh_row(refresh_row), .refresh_strobe(), .protocol_error(protocol_error)
  );
  ////////////////////////////////////////////////////////////
  // Clock and cycle ceiling
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 6000) begin
      fails++;
      $display("mismatch at %0t: run too long", $time);
      end_sim();
    end
  end

  task automatic check(input logic [12:0] seen, input logic [12:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    // Auto-precharge on bank 1 while bank 2 opens
    u_dpr_ctrl_model.issue(1'b1, C_ACT, 2'h1, 1'b0, 4);
    u_dpr_ctrl_model.issue(1'b1, C_WR, 2'h1, 1'b1, 1);
    u_dpr_ctrl_model.issue(1'b1, C_ACT, 2'h2, 1'b0, 5);
    #1;
    check(13'(bank_status.open), 13'h6);
    u_dpr_ctrl_model.issue(1'b1, C_NOP, 2'h0, 1'b0, 30);
    #1;
    check(13'(bank_status), 13'h40);
    $display("test 1 done");
    // Auto-refresh after closing all banks
    u_dpr_ctrl_model.issue(1'b1, C_PRE, 2'h0, 1'b1, 6);
    u_dpr_ctrl_model.issue(1'b1, C_REF, 2'h3, 1'b1, 40);
    #1;
    check(refresh_row, 13'h0001);
    check(13'({bank_status, power.refresh_busy}), 13'h0);
    $display("test 2 done");
    // Precharge, fast and slow active power-down
    for (int k = 0; k < 3; k++) begin
      @(posedge core_clk);
      mode.pd_slow <= (k == 2);
      if (k > 0) begin
        u_dpr_ctrl_model.issue(1'b1, C_ACT, 2'h0, 1'b0, 4);
      end
      u_dpr_ctrl_model.issue(1'b0, C_NOP, 2'h0, 1'b0, 6);
      #1;
      check(13'(pwr_state), 13'(pd_tab[k]));
      check(13'({power.in_buf_en, power.out_buf_en, power.dll_en}), 13'(k == 1));
      u_dpr_ctrl_model.issue(1'b1, C_NOP, 2'h0, 1'b0, 6);
      #1;
      check(13'(pwr_state), 13'(PS_ACTIVE));
      u_dpr_ctrl_model.issue(1'b1, C_PRE, 2'h0, 1'b1, 6);
    end
    $display("test 3 done");
    // Self-refresh ignores commands and refreshes by its own timer
    u_dpr_ctrl_model.issue(1'b0, C_REF, 2'h0, 1'b0, 4);
    u_dpr_ctrl_model.issue(1'b0, C_ACT, 2'h3, 1'b0, 2000);
    #1;
    check(13'(pwr_state), 13'(PS_SELF));
    check(13'({bank_status.open, refresh_row > 13'h0001}), 13'h1);
    u_dpr_ctrl_model.issue(1'b1, C_NOP, 2'h0, 1'b0, 10);
    #1;
    check(13'({pwr_state, protocol_error}), 13'({PS_ACTIVE, 1'b0}));
    $display("test 4 done");
    // Write recovery outside its range is flagged
    @(posedge core_clk);
    mode.wr <= 3'h7;
    u_dpr_ctrl_model.issue(1'b1, C_ACT, 2'h0, 1'b0, 12);
    u_dpr_ctrl_model.issue(1'b1, C_WR, 2'h0, 1'b0, 6);
    #1;
    check(13'(protocol_error), 13'h1);
    $display("test 5 done");
    end_sim();
  end
endmodule : test_ddr2_precharge_refresh_powerdown
